/* rtl/epc_irq.sv */
// interrupt source logic: external edges, timer0 overflow, pin change groups
// assumes synchronous inputs on core_clk and a core that acknowledges entry
//
// The strobed register port was decided locally.
`timescale 1ns/100ps
`include "epc_params.svh"
module epc_irq (
    // clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // register port
    input wire epc_pkg::epc_bus_type bus,
    output logic [7:0] rdata,
    // pins and timer
    input wire logic [3:0] ext_pins,
    input wire logic [15:0] change_sources,
    input wire logic [15:0] timer0_count_pair,
    // core side
    input wire logic sleep_mode,
    input wire logic entry,
    input wire epc_pkg::epc_ctx_type ctx,
    output logic irq_high,
    output logic irq_low,
    output epc_pkg::epc_vec_type irq_vector,
    output logic wake,
    output logic stack_push,
    output logic [20:0] stack_pc,
    output logic [7:0] fast_working_register,
    output logic [7:0] fast_status,
    output logic [7:0] fast_bsr
);
    // ************************************************
    // decode
    // ************************************************
    function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    logic wr_mask_lo;
    logic wr_mask_hi;
    logic wr_gflags;
    logic wr_genable;
    logic wr_third;
    logic wr_second;
    logic wr_main;
    logic wr_eflags;
    assign wr_mask_lo = bus.wr & hit(bus.addr, `EPC_OFS_MASK_LOW);
    assign wr_mask_hi = bus.wr & hit(bus.addr, `EPC_OFS_MASK_HIGH);
    assign wr_gflags = bus.wr & hit(bus.addr, `EPC_OFS_GROUP_FLAGS);
    assign wr_genable = bus.wr & hit(bus.addr, `EPC_OFS_GROUP_ENABLE);
    assign wr_third = bus.wr & hit(bus.addr, `EPC_OFS_THIRD_CTRL);
    assign wr_second = bus.wr & hit(bus.addr, `EPC_OFS_SECOND_CTRL);
    assign wr_main = bus.wr & hit(bus.addr, `EPC_OFS_MAIN_CTRL);
    assign wr_eflags = bus.wr & hit(bus.addr, `EPC_OFS_EXT_FLAGS);

    // ************************************************
    // synchronisers and change detect
    // ************************************************
    logic [3:0] ext_s1;
    logic [3:0] ext_s2;
    logic [3:0] ext_prev;
    logic [15:0] chg_s1;
    logic [15:0] chg_s2;
    logic [15:0] chg_prev;
    logic [15:0] t0_prev;
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            ext_s1 <= 4'h0;
            ext_s2 <= 4'h0;
            ext_prev <= 4'h0;
            chg_s1 <= 16'h0000;
            chg_s2 <= 16'h0000;
            chg_prev <= 16'h0000;
            t0_prev <= 16'h0000;
        end else begin
            ext_s1 <= ext_pins;
            ext_s2 <= ext_s1;
            ext_prev <= ext_s2;
            chg_s1 <= change_sources;
            chg_s2 <= chg_s1;
            chg_prev <= chg_s2;
            t0_prev <= timer0_count_pair;
        end
    end

    // ************************************************
    // control registers
    // ************************************************
    logic [7:0] mask_lo;
    logic [7:0] mask_hi;
    logic [1:0] group_en;
    logic [3:0] edge_sel;
    logic [3:0] ext_en;
    logic [3:1] ext_prio;
    logic global_irq_enable;
    logic t0_en;
    logic t0_prio;
    logic t0_wide;
    logic [7:0] next_mask_lo;
    logic [7:0] next_mask_hi;
    logic [1:0] next_group_en;
    logic [3:0] next_edge_sel;
    logic [3:0] next_ext_en;
    logic [3:1] next_ext_prio;
    logic next_gie;
    logic next_t0_en;
    logic next_t0_prio;
    logic next_t0_wide;
    always_comb begin
        next_mask_lo = wr_mask_lo ? bus.wdata : mask_lo;
        next_mask_hi = wr_mask_hi ? bus.wdata : mask_hi;
        next_group_en = wr_genable ? bus.wdata[1:0] : group_en;
        next_edge_sel = wr_second ? bus.wdata[`EPC_POS_EDGE_SEL+:4] : edge_sel;
        next_ext_prio = ext_prio;
        next_t0_prio = t0_prio;
        next_t0_wide = t0_wide;
        next_ext_en = wr_third ? bus.wdata[3:0] : ext_en;
        next_gie = wr_main ? bus.wdata[`EPC_BIT_GIE] : global_irq_enable;
        next_t0_en = wr_main ? bus.wdata[`EPC_BIT_T0_EN] : t0_en;
        if (wr_second) begin
            next_ext_prio[3] = bus.wdata[`EPC_BIT_EXT3_PRIO];
            next_t0_prio = bus.wdata[`EPC_BIT_T0_PRIO];
            next_t0_wide = bus.wdata[`EPC_BIT_T0_WIDE];
        end
        if (wr_third) begin
            next_ext_prio[2] = bus.wdata[`EPC_BIT_EXT2_PRIO];
            next_ext_prio[1] = bus.wdata[`EPC_BIT_EXT1_PRIO];
        end
    end
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            mask_lo <= `EPC_RST_BYTE;
            mask_hi <= `EPC_RST_BYTE;
            group_en <= 2'b00;
            edge_sel <= `EPC_RST_EDGE_SEL;
            ext_en <= 4'h0;
            ext_prio <= {3{`EPC_RST_PRIO}};
            global_irq_enable <= 1'b0;
            t0_en <= 1'b0;
            t0_prio <= `EPC_RST_PRIO;
            t0_wide <= 1'b0;
        end else begin
            mask_lo <= next_mask_lo;
            mask_hi <= next_mask_hi;
            group_en <= next_group_en;
            edge_sel <= next_edge_sel;
            ext_en <= next_ext_en;
            ext_prio <= next_ext_prio;
            global_irq_enable <= next_gie;
            t0_en <= next_t0_en;
            t0_prio <= next_t0_prio;
            t0_wide <= next_t0_wide;
        end
    end

    // ************************************************
    // event flags
    // ************************************************
    logic [3:0] ext_edge;
    logic [15:0] pc_chg;
    logic [1:0] pc_set;
    logic t0_wrap;
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_edge
            assign ext_edge[gi] = edge_sel[gi] ? (ext_s2[gi] & ~ext_prev[gi])
                                               : (~ext_s2[gi] & ext_prev[gi]);
        end
    endgenerate
    assign pc_chg = chg_s2 ^ chg_prev;
    assign pc_set[0] = group_en[0] & |(pc_chg[7:0] & mask_lo);
    assign pc_set[1] = group_en[1] & |(pc_chg[15:8] & mask_hi);
    assign t0_wrap = t0_wide ? (t0_prev == 16'hffff && timer0_count_pair == 16'h0000)
                             : (t0_prev[7:0] == 8'hff && timer0_count_pair[7:0] == 8'h00);

    logic [3:0] ext_flag;
    logic [1:0] pc_flag;
    logic t0_flag;
    logic [3:0] next_ext_flag;
    logic [1:0] next_pc_flag;
    logic next_t0_flag;
    always_comb begin
        next_ext_flag = ext_flag;
        next_pc_flag = pc_flag;
        next_t0_flag = t0_flag;
        if (wr_eflags) begin
            next_ext_flag = ext_flag & bus.wdata[3:0];
        end
        if (wr_gflags) begin
            next_pc_flag = pc_flag & bus.wdata[1:0];
        end
        if (wr_main) begin
            next_t0_flag = t0_flag & bus.wdata[`EPC_BIT_T0_FLAG];
        end
        next_ext_flag = next_ext_flag | ext_edge;
        next_pc_flag = next_pc_flag | pc_set;
        next_t0_flag = next_t0_flag | t0_wrap;
    end
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            ext_flag <= 4'h0;
            pc_flag <= 2'b00;
            t0_flag <= 1'b0;
        end else begin
            ext_flag <= next_ext_flag;
            pc_flag <= next_pc_flag;
            t0_flag <= next_t0_flag;
        end
    end

    // ************************************************
    // requests and vector
    // ************************************************
    logic [3:0] ext_req;
    logic t0_req;
    logic [3:0] ext_hi;
    logic any_high;
    logic any_low;
    epc_pkg::epc_vec_type sel_vec;
    assign ext_req = ext_flag & ext_en;
    assign t0_req = t0_flag & t0_en;
    assign ext_hi = {ext_prio, 1'b1};
    assign any_high = |(ext_req & ext_hi) | (t0_req & t0_prio) | (|pc_flag);
    assign any_low = |(ext_req & ~ext_hi) | (t0_req & ~t0_prio);
    always_comb begin
        sel_vec = epc_pkg::EPC_VEC_NONE;
        if (ext_req[0]) sel_vec = epc_pkg::EPC_VEC_EXT0;
        else if (ext_req[1] & ext_hi[1]) sel_vec = epc_pkg::EPC_VEC_EXT1;
        else if (ext_req[2] & ext_hi[2]) sel_vec = epc_pkg::EPC_VEC_EXT2;
        else if (ext_req[3] & ext_hi[3]) sel_vec = epc_pkg::EPC_VEC_EXT3;
        else if (t0_req & t0_prio) sel_vec = epc_pkg::EPC_VEC_T0;
        else if (pc_flag[0]) sel_vec = epc_pkg::EPC_VEC_CHG0;
        else if (pc_flag[1]) sel_vec = epc_pkg::EPC_VEC_CHG1;
        else if (ext_req[1]) sel_vec = epc_pkg::EPC_VEC_EXT1;
        else if (ext_req[2]) sel_vec = epc_pkg::EPC_VEC_EXT2;
        else if (ext_req[3]) sel_vec = epc_pkg::EPC_VEC_EXT3;
        else if (t0_req) sel_vec = epc_pkg::EPC_VEC_T0;
    end

    // ************************************************
    // sleep and wake
    // ************************************************
    epc_pkg::epc_ps_type ps;
    epc_pkg::epc_ps_type next_ps;
    logic [3:0] sleep_en;
    logic [3:0] next_sleep_en;
    always_comb begin
        next_ps = ps;
        next_sleep_en = sleep_en;
        case (ps)
            epc_pkg::EPC_PS_RUN: begin
                if (sleep_mode) begin
                    next_ps = epc_pkg::EPC_PS_SLEEP;
                    next_sleep_en = ext_en;
                end
            end
            epc_pkg::EPC_PS_SLEEP: begin
                if (|(ext_flag & sleep_en)) next_ps = epc_pkg::EPC_PS_WAKE;
                else if (!sleep_mode) next_ps = epc_pkg::EPC_PS_RUN;
            end
            epc_pkg::EPC_PS_WAKE: begin
                if (!sleep_mode) next_ps = epc_pkg::EPC_PS_RUN;
            end
            default: next_ps = epc_pkg::EPC_PS_RUN;
        endcase
    end

    // ************************************************
    // outputs and context save
    // ************************************************
    logic [7:0] next_rdata;
    always_comb begin
        next_rdata = 8'h00;
        if (bus.rd) begin
            case (bus.addr)
                `EPC_OFS_MASK_LOW: next_rdata = mask_lo;
                `EPC_OFS_MASK_HIGH: next_rdata = mask_hi;
                `EPC_OFS_GROUP_FLAGS: next_rdata = {6'b000000, pc_flag};
                `EPC_OFS_GROUP_ENABLE: next_rdata = {6'b000000, group_en};
                `EPC_OFS_THIRD_CTRL: next_rdata = {ext_prio[2], ext_prio[1], 2'b00, ext_en};
                `EPC_OFS_SECOND_CTRL: next_rdata = {edge_sel, 1'b0, t0_prio, ext_prio[3], t0_wide};
                `EPC_OFS_MAIN_CTRL: next_rdata = {global_irq_enable, 1'b0, t0_en, 2'b00, t0_flag, 2'b00};
                `EPC_OFS_EXT_FLAGS: next_rdata = {4'h0, ext_flag};
                default: next_rdata = 8'h00;
            endcase
        end
    end
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            ps <= epc_pkg::EPC_PS_RUN;
            sleep_en <= 4'h0;
            rdata <= 8'h00;
            irq_high <= 1'b0;
            irq_low <= 1'b0;
            irq_vector <= epc_pkg::EPC_VEC_NONE;
            wake <= 1'b0;
            stack_push <= 1'b0;
            stack_pc <= 21'h00_0000;
            fast_working_register <= 8'h00;
            fast_status <= 8'h00;
            fast_bsr <= 8'h00;
        end else begin
            ps <= next_ps;
            sleep_en <= next_sleep_en;
            rdata <= next_rdata;
            irq_high <= global_irq_enable & any_high;
            irq_low <= global_irq_enable & any_low;
            irq_vector <= global_irq_enable ? sel_vec : epc_pkg::EPC_VEC_NONE;
            wake <= (next_ps == epc_pkg::EPC_PS_WAKE);
            stack_push <= entry;
            if (entry) begin
                stack_pc <= ctx.pc;
                fast_working_register <= ctx.working_register;
                fast_status <= ctx.status;
                fast_bsr <= ctx.bank_select_register;
            end
        end
    end

    // ************************************************
    // checks
    // ************************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    a_rise_sets_flag: assert property (
        $rose(ext_s2[0]) && edge_sel[0] |=> ext_flag[0])
        else $error("rising edge did not set flag");
    a_fall_sets_flag: assert property (
        $fell(ext_s2[1]) && !edge_sel[1] |=> ext_flag[1])
        else $error("falling edge did not set flag");
    a_group0_change: assert property (
        group_en[0] && |(pc_chg[7:0] & mask_lo) |=> pc_flag[0])
        else $error("group zero change lost");
    a_group1_off: assert property (
        !group_en[1] && !pc_flag[1] |=> !pc_flag[1])
        else $error("disabled group one flag set");
    a_reserved_zero: assert property (
        bus.rd && bus.addr == `EPC_OFS_GROUP_ENABLE |=> rdata[7:2] == 6'b000000)
        else $error("reserved bits not zero");
    a_t0_byte_wrap: assert property (
        !t0_wide ##0 $past(timer0_count_pair[7:0]) == 8'hff && timer0_count_pair[7:0] == 8'h00
        |=> t0_flag)
        else $error("timer0 wrap missed");
    a_gie_gates_irq: assert property (
        !global_irq_enable |=> !irq_high && !irq_low)
        else $error("request without global enable");
    a_ext0_high: assert property (
        ext_flag[0] && ext_en[0] && global_irq_enable |=> irq_high && irq_vector == epc_pkg::EPC_VEC_EXT0)
        else $error("input zero not high priority");
    a_ctx_save: assert property (
        entry |=> stack_push && fast_working_register == $past(ctx.working_register) && stack_pc == $past(ctx.pc))
        else $error("context not saved");
    a_sleep_wake: assert property (
        ps == epc_pkg::EPC_PS_SLEEP && |(ext_flag & sleep_en) |=> wake)
        else $error("enabled input did not wake");
endmodule : epc_irq

/* rtl/epc_params.svh */
// constants of the interrupt source block: offsets, field positions, reset values
// assumes byte-wide registers reached over a plain strobe port
// What this block does
// - edge select bit picks rising or falling
// - qualifying edge sets that input's flag
// - enabled external edge wakes from sleep
// - vectoring after wake needs global enable
// - inputs one to three follow priority bits
// - input zero is always high priority
// - 8-bit wrap sets timer0 overflow flag
// - 16-bit wrap sets timer0 overflow flag
// - timer0 request gated by enable, own priority
// - masked port changes set group flags
// - change sources are always high priority
// - group-one enable bit one, own vector
// - group-zero enable bit zero, own vector
// - reserved bits seven to two read zero
// - group-one flag sets, write zero clears
// - group-zero flag sets, write zero clears
// - mask high and group enable both needed
// - mask low and group enable both needed
// - entry saves return address and fast context
`ifndef EPC_PARAMS_SVH
`define EPC_PARAMS_SVH
`define EPC_OFS_MASK_LOW 12'hf99
`define EPC_OFS_MASK_HIGH 12'hf9a
`define EPC_OFS_GROUP_FLAGS 12'hf9b
`define EPC_OFS_GROUP_ENABLE 12'hf9c
`define EPC_OFS_THIRD_CTRL 12'hff0
`define EPC_OFS_SECOND_CTRL 12'hff1
`define EPC_OFS_MAIN_CTRL 12'hff2
`define EPC_OFS_EXT_FLAGS 12'hff3
`define EPC_BIT_GIE 7
`define EPC_BIT_T0_EN 5
`define EPC_BIT_T0_FLAG 2
`define EPC_BIT_T0_PRIO 2
`define EPC_BIT_EXT3_PRIO 1
`define EPC_BIT_T0_WIDE 0
`define EPC_BIT_EXT2_PRIO 7
`define EPC_BIT_EXT1_PRIO 6
`define EPC_POS_EDGE_SEL 4
`define EPC_RST_BYTE 8'h00
`define EPC_RST_PRIO 1'b1
`define EPC_RST_EDGE_SEL 4'hf
`endif

/* rtl/epc_pkg.sv */
// types of the interrupt source block
// assumes epc_params.svh carries the numbers
package epc_pkg;
    typedef struct packed {
        logic [11:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } epc_bus_type;
    typedef struct packed {
        logic [20:0] pc;
        logic [7:0] working_register;
        logic [7:0] status;
        logic [7:0] bank_select_register;
    } epc_ctx_type;
    typedef enum logic [3:0] {
        EPC_VEC_NONE = 4'h0,
        EPC_VEC_EXT0 = 4'h1,
        EPC_VEC_EXT1 = 4'h2,
        EPC_VEC_EXT2 = 4'h3,
        EPC_VEC_EXT3 = 4'h4,
        EPC_VEC_T0 = 4'h5,
        EPC_VEC_CHG0 = 4'h6,
        EPC_VEC_CHG1 = 4'h7
    } epc_vec_type;
    typedef enum logic [1:0] {
        EPC_PS_RUN = 2'b00,
        EPC_PS_SLEEP = 2'b01,
        EPC_PS_WAKE = 2'b11
    } epc_ps_type;
endpackage : epc_pkg

/* verif/epc_far_side.sv */
// far side model: external pins, timer0 count and the interrupted core
// assumes its tasks are called from the bench thread, clocked by core_clk
`timescale 1ns/100ps
module epc_far_side (
    // clock and requests
    input wire logic core_clk,
    input wire logic irq_high,
    input wire logic irq_low,
    // pins and timer
    output logic [3:0] ext_pins,
    output logic [15:0] change_sources,
    output logic [15:0] timer0_count_pair,
    // core
    output logic sleep_mode,
    output logic entry,
    output epc_pkg::epc_ctx_type ctx
);
    // ****************************************
    // stimulus tasks
    // ****************************************
    initial begin
        ext_pins = 4'h0;
        change_sources = 16'h0000;
        timer0_count_pair = 16'h0000;
        sleep_mode = 1'b0;
        entry = 1'b0;
        ctx = '0;
    end
    task automatic pins(input logic [3:0] e, input logic [15:0] c);
        @(posedge core_clk);
        ext_pins <= e;
        change_sources <= c;
    endtask : pins
    task automatic count(input logic [15:0] v);
        @(posedge core_clk);
        timer0_count_pair <= v;
    endtask : count
    task automatic doze(input logic s);
        @(posedge core_clk);
        sleep_mode <= s;
    endtask : doze
    // core waits for a request, then enters with fast return, so software saves nothing
    task automatic enter(input epc_pkg::epc_ctx_type c, output logic seen);
        int n;
        seen = 1'b0;
        for (n = 0; n < 20 && !seen; n++) begin
            @(negedge core_clk);
            seen = (irq_high === 1'b1) || (irq_low === 1'b1);
        end
        if (seen) begin
            @(posedge core_clk);
            entry <= 1'b1;
            ctx <= c;
            @(posedge core_clk);
            entry <= 1'b0;
            ctx <= ~c;
        end
    endtask : enter
endmodule : epc_far_side

/* verif/epc_irq_bench.sv */
// self-checking bench of the interrupt source block
// assumes epc_far_side drives pins, timer and core; bench owns the register port
`timescale 1ns/100ps
`include "epc_params.svh"
module epc_irq_bench;
    logic core_clk;
    logic nrst;
    epc_pkg::epc_bus_type bus;
    logic [7:0] rdata;
    logic [3:0] ext_pins;
    logic [15:0] change_sources;
    logic [15:0] timer0_count_pair;
    logic sleep_mode;
    logic entry;
    epc_pkg::epc_ctx_type ctx;
    logic irq_high;
    logic irq_low;
    epc_pkg::epc_vec_type irq_vector;
    logic wake;
    logic stack_push;
    logic [20:0] stack_pc;
    logic [7:0] fast_working_register;
    logic [7:0] fast_status;
    logic [7:0] fast_bsr;
    int errors;
    int comparisons;

    epc_irq epc_irq_inst (.core_clk(core_clk), .nrst(nrst), .bus(bus), .rdata(rdata), .ext_pins(ext_pins),
        .change_sources(change_sources), .timer0_count_pair(timer0_count_pair), .sleep_mode(sleep_mode),
        .entry(entry), .ctx(ctx), .irq_high(irq_high), .irq_low(irq_low), .irq_vector(irq_vector), .wake(wake),
        .stack_push(stack_push), .stack_pc(stack_pc), .fast_working_register(fast_working_register), .fast_status(fast_status),
        .fast_bsr(fast_bsr));
    epc_far_side epc_far_side_inst (.core_clk(core_clk), .irq_high(irq_high), .irq_low(irq_low),
        .ext_pins(ext_pins), .change_sources(change_sources), .timer0_count_pair(timer0_count_pair),
        .sleep_mode(sleep_mode), .entry(entry), .ctx(ctx));

    // ****************************************
    // helpers
    // ****************************************
    task automatic chk(input logic [20:0] got, input logic [20:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic chk_vec(input epc_pkg::epc_vec_type got, input epc_pkg::epc_vec_type exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk_vec
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge core_clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        bus.wr <= 1'b0;
    endtask : wr
    task automatic rdchk(input logic [11:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        bus.rd <= 1'b0;
        @(negedge core_clk);
        chk({13'h0000, rdata}, {13'h0000, exp});
    endtask : rdchk
    task automatic settle;
        repeat (6) @(posedge core_clk);
    endtask : settle
    task automatic irqchk(input logic h, input logic l, input epc_pkg::epc_vec_type v);
        settle();
        @(negedge core_clk);
        chk({20'h0_0000, irq_high}, {20'h0_0000, h});
        chk({20'h0_0000, irq_low}, {20'h0_0000, l});
        chk_vec(irq_vector, v);
    endtask : irqchk
    task automatic final_report;
        if (errors == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : final_report

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset;
        rdchk(`EPC_OFS_MASK_LOW, 8'h00);
        rdchk(`EPC_OFS_MASK_HIGH, 8'h00);
        rdchk(`EPC_OFS_GROUP_FLAGS, 8'h00);
        rdchk(`EPC_OFS_GROUP_ENABLE, 8'h00);
        rdchk(`EPC_OFS_THIRD_CTRL, 8'hc0);
        rdchk(`EPC_OFS_SECOND_CTRL, 8'hf6);
        rdchk(`EPC_OFS_MAIN_CTRL, 8'h00);
        rdchk(12'h000, 8'h00);
        wr(`EPC_OFS_MASK_HIGH, 8'ha5);
        rdchk(`EPC_OFS_MASK_HIGH, 8'ha5);
        wr(`EPC_OFS_GROUP_ENABLE, 8'hff);
        rdchk(`EPC_OFS_GROUP_ENABLE, 8'h03);
        wr(`EPC_OFS_GROUP_FLAGS, 8'hff);
        rdchk(`EPC_OFS_GROUP_FLAGS, 8'h00);
        wr(`EPC_OFS_GROUP_ENABLE, 8'h00);
        wr(`EPC_OFS_MASK_HIGH, 8'h00);
    endtask : t_reset
    task automatic t_edges;
        int i;
        for (i = 0; i < 4; i++) begin
            epc_far_side_inst.pins(4'h1 << i, 16'h0000);
            settle();
            rdchk(`EPC_OFS_EXT_FLAGS, 8'h01 << i);
            wr(`EPC_OFS_EXT_FLAGS, 8'h00);
            wr(`EPC_OFS_SECOND_CTRL, 8'hf6 & ~(8'h10 << i));
            epc_far_side_inst.pins(4'h0, 16'h0000);
            settle();
            rdchk(`EPC_OFS_EXT_FLAGS, 8'h01 << i);
            wr(`EPC_OFS_EXT_FLAGS, 8'h00);
            epc_far_side_inst.pins(4'h1 << i, 16'h0000);
            settle();
            rdchk(`EPC_OFS_EXT_FLAGS, 8'h00);
            wr(`EPC_OFS_SECOND_CTRL, 8'hf6);
            epc_far_side_inst.pins(4'h0, 16'h0000);
            settle();
            rdchk(`EPC_OFS_EXT_FLAGS, 8'h00);
        end
    endtask : t_edges
    task automatic t_prio;
        int i;
        wr(`EPC_OFS_MAIN_CTRL, 8'h80);
        wr(`EPC_OFS_THIRD_CTRL, 8'h8f);
        wr(`EPC_OFS_SECOND_CTRL, 8'hf4);
        for (i = 0; i < 4; i++) begin
            epc_far_side_inst.pins(4'h1 << i, 16'h0000);
            irqchk(!i[0], i[0], epc_pkg::epc_vec_type'(i + 1));
            wr(`EPC_OFS_EXT_FLAGS, 8'h00);
            epc_far_side_inst.pins(4'h0, 16'h0000);
            irqchk(1'b0, 1'b0, epc_pkg::EPC_VEC_NONE);
        end
        wr(`EPC_OFS_THIRD_CTRL, 8'h8e);
        epc_far_side_inst.pins(4'h1, 16'h0000);
        irqchk(1'b0, 1'b0, epc_pkg::EPC_VEC_NONE);
        rdchk(`EPC_OFS_EXT_FLAGS, 8'h01);
        wr(`EPC_OFS_EXT_FLAGS, 8'h00);
        epc_far_side_inst.pins(4'h0, 16'h0000);
        wr(`EPC_OFS_THIRD_CTRL, 8'hc0);
        wr(`EPC_OFS_SECOND_CTRL, 8'hf6);
        wr(`EPC_OFS_MAIN_CTRL, 8'h00);
    endtask : t_prio
    task automatic t_timer;
        epc_far_side_inst.count(16'h00fe);
        epc_far_side_inst.count(16'h00ff);
        epc_far_side_inst.count(16'h0100);
        settle();
        rdchk(`EPC_OFS_MAIN_CTRL, 8'h04);
        wr(`EPC_OFS_MAIN_CTRL, 8'h00);
        wr(`EPC_OFS_SECOND_CTRL, 8'hf7);
        epc_far_side_inst.count(16'h12ff);
        epc_far_side_inst.count(16'h1300);
        settle();
        rdchk(`EPC_OFS_MAIN_CTRL, 8'h00);
        epc_far_side_inst.count(16'hffff);
        epc_far_side_inst.count(16'h0000);
        settle();
        rdchk(`EPC_OFS_MAIN_CTRL, 8'h04);
        wr(`EPC_OFS_MAIN_CTRL, 8'h84);
        irqchk(1'b0, 1'b0, epc_pkg::EPC_VEC_NONE);
        wr(`EPC_OFS_MAIN_CTRL, 8'ha4);
        irqchk(1'b1, 1'b0, epc_pkg::EPC_VEC_T0);
        wr(`EPC_OFS_SECOND_CTRL, 8'hf3);
        irqchk(1'b0, 1'b1, epc_pkg::EPC_VEC_T0);
        wr(`EPC_OFS_MAIN_CTRL, 8'h80);
        irqchk(1'b0, 1'b0, epc_pkg::EPC_VEC_NONE);
        wr(`EPC_OFS_SECOND_CTRL, 8'hf6);
    endtask : t_timer
    task automatic t_change;
        wr(`EPC_OFS_MASK_LOW, 8'h08);
        wr(`EPC_OFS_MASK_HIGH, 8'h80);
        epc_far_side_inst.pins(4'h0, 16'h0008);
        settle();
        rdchk(`EPC_OFS_GROUP_FLAGS, 8'h00);
        wr(`EPC_OFS_GROUP_ENABLE, 8'h01);
        epc_far_side_inst.pins(4'h0, 16'h000c);
        settle();
        rdchk(`EPC_OFS_GROUP_FLAGS, 8'h00);
        epc_far_side_inst.pins(4'h0, 16'h0000);
        settle();
        rdchk(`EPC_OFS_GROUP_FLAGS, 8'h01);
        irqchk(1'b1, 1'b0, epc_pkg::EPC_VEC_CHG0);
        wr(`EPC_OFS_GROUP_FLAGS, 8'h02);
        rdchk(`EPC_OFS_GROUP_FLAGS, 8'h00);
        epc_far_side_inst.pins(4'h0, 16'h8000);
        settle();
        rdchk(`EPC_OFS_GROUP_FLAGS, 8'h00);
        wr(`EPC_OFS_GROUP_ENABLE, 8'h03);
        epc_far_side_inst.pins(4'h0, 16'h0000);
        settle();
        rdchk(`EPC_OFS_GROUP_FLAGS, 8'h02);
        irqchk(1'b1, 1'b0, epc_pkg::EPC_VEC_CHG1);
        wr(`EPC_OFS_GROUP_FLAGS, 8'h01);
        rdchk(`EPC_OFS_GROUP_FLAGS, 8'h00);
        wr(`EPC_OFS_MASK_HIGH, 8'h00);
        epc_far_side_inst.pins(4'h0, 16'h8000);
        settle();
        rdchk(`EPC_OFS_GROUP_FLAGS, 8'h00);
        wr(`EPC_OFS_GROUP_ENABLE, 8'h00);
        wr(`EPC_OFS_MASK_LOW, 8'h00);
        wr(`EPC_OFS_MAIN_CTRL, 8'h00);
    endtask : t_change
    task automatic t_sleep_entry;
        logic seen;
        wr(`EPC_OFS_THIRD_CTRL, 8'hc4);
        epc_far_side_inst.doze(1'b1);
        epc_far_side_inst.pins(4'h4, 16'h8000);
        irqchk(1'b0, 1'b0, epc_pkg::EPC_VEC_NONE);
        chk({20'h0_0000, wake}, 21'h0_0001);
        epc_far_side_inst.doze(1'b0);
        settle();
        chk({20'h0_0000, wake}, 21'h0_0000);
        wr(`EPC_OFS_MAIN_CTRL, 8'h80);
        irqchk(1'b1, 1'b0, epc_pkg::EPC_VEC_EXT2);
        epc_far_side_inst.enter('{pc: 21'h1_2345, working_register: 8'ha5, status: 8'h3c, bank_select_register: 8'h0f}, seen);
        @(negedge core_clk);
        chk({20'h0_0000, seen & stack_push}, 21'h0_0001);
        chk(stack_pc, 21'h1_2345);
        chk({fast_working_register, fast_status, 5'h00}, {8'ha5, 8'h3c, 5'h00});
        chk({13'h0000, fast_bsr}, {13'h0000, 8'h0f});
        @(negedge core_clk);
        chk({20'h0_0000, stack_push}, 21'h0_0000);
        chk({fast_working_register, fast_status, 5'h00}, {8'ha5, 8'h3c, 5'h00});
        chk({13'h0000, fast_bsr}, {13'h0000, 8'h0f});
        wr(`EPC_OFS_EXT_FLAGS, 8'h00);
        wr(`EPC_OFS_MAIN_CTRL, 8'h00);
    endtask : t_sleep_entry
    task automatic t_rerun;
        wr(`EPC_OFS_MASK_LOW, 8'h5a);
        wr(`EPC_OFS_MAIN_CTRL, 8'ha0);
        wr(`EPC_OFS_SECOND_CTRL, 8'h01);
        @(posedge core_clk);
        nrst <= 1'b0;
        repeat (2) @(posedge core_clk);
        nrst <= 1'b1;
        rdchk(`EPC_OFS_MASK_LOW, 8'h00);
        rdchk(`EPC_OFS_MAIN_CTRL, 8'h00);
        rdchk(`EPC_OFS_SECOND_CTRL, 8'hf6);
        irqchk(1'b0, 1'b0, epc_pkg::EPC_VEC_NONE);
    endtask : t_rerun

    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    initial begin
        #40000;
        errors++;
        final_report();
    end
    initial begin
        errors = 0;
        comparisons = 0;
        nrst = 1'b0;
        bus = '0;
        repeat (2) @(posedge core_clk);
        nrst <= 1'b1;
        t_reset();
        t_edges();
        t_prio();
        t_timer();
        t_change();
        t_sleep_entry();
        t_rerun();
        final_report();
    end
endmodule : epc_irq_bench
